/* core/afe_mclk_div.v */
`timescale 1ns/100ps
// Master clock output: a clock at half the system clock
module afe_mclk_div (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire en_i,
    // Clock out
    output wire mclk_o
);
    reg ph_q;

    ////////////////////////////////////////////////////////////////
    // Halving uses both edges; the register toggles each cycle and
    // XOR with clk gives one edge per clk period. Glitch-prone, kept small.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
        end
    end

    assign mclk_o = en_i & (clk_i ^ ph_q);
endmodule

/* core/afe_strobe_gen.v */
`timescale 1ns/100ps
// Data-ready strobe: a fixed-width high pulse per trigger
module afe_strobe_gen #(
    parameter CW = 4
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire trig_i,
    input wire [CW-1:0] width_i,
    // Strobe
    output wire strobe_o,
    output wire rise_o
);
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;

    ////////////////////////////////////////////////////////////////
    // A trigger during a pulse restarts it, but rise_o fires only for a trigger while idle
    always @* begin
        cnt_d = cnt_q;
        if (trig_i) begin
            cnt_d = width_i;
        end else if (cnt_q != {CW{1'b0}}) begin
            cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= {CW{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign strobe_o = (cnt_q != {CW{1'b0}});
    assign rise_o = trig_i & (cnt_q == {CW{1'b0}});
endmodule

/* core/afe_system_config_bank.v */
`timescale 1ns/100ps
`include "afe_sys_map.vh"
// Function
// - Enabled general outputs follow output data bits 15..6 as pins 9..0.
// - Data-ready strobe lasts 2 cycles with width bit 0, 8 with 1.
// - Results are 24 bits with short-result bit 0, 16 bits with 1.
// - Prepended status is sticky with bit 0, sampled live at strobe with 1.
// - Master clock output bit puts half-rate clock on pin nine, overriding all.
// - Reference field picks internal or external bypass and ADC references.
// - Clock source field picks oscillator, external clock or crystal.
// - CRC protection runs only while the CRC enable bit is one.
// - Status enable prepends an 8-bit status byte before each channel word.
// - First status byte of a burst is OR of all burst channel status.
// - Sync mode starts conversion on rising SYNC edge from the host.
// - Edge bit 0 strobes every conversion; 1 only after last channel.
// - Policy 0 clears alarms on read; policy 1 clears by writing one.
// - Interrupt pin is open-drain with pull-up or push-pull per driver bit.
module afe_system_config_bank #(
    parameter NPIN = 10,
    parameter NALM = 16,
    parameter NCH = 16
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register port from the SPI command decoder
    input wire [6:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    // General pins
    input wire [NPIN-1:0] gpo_enable_i,
    output reg [NPIN-1:0] gpio_out_o,
    output reg [NPIN-1:0] gpio_oe_o,
    // Conversion events and result shaping
    input wire conv_done_i,
    input wire conv_last_i,
    input wire [23:0] conv_data_i,
    input wire [7:0] conv_status_i,
    input wire burst_first_i,
    input wire [NCH-1:0] channel_enable_mask_i,
    input wire [NCH-1:0] burst_mask_i,
    input wire [8*NCH-1:0] ch_status_i,
    output reg [23:0] result_o,
    output reg [7:0] status_byte_o,
    output wire status_prepend_o,
    output wire short_result_sel_o,
    output wire data_ready_strobe_o,
    // Sync start
    input wire sync_pin_i,
    output wire conv_start_o,
    // Analog and clock steering
    output wire bypass_external_reference_o,
    output wire adc_external_reference_o,
    output wire use_int_osc_o,
    output wire xtal_osc_en_o,
    output wire ext_clk_sel_o,
    output wire crc_en_o,
    output wire dout_drive_hi_o,
    // Global alarm events
    input wire [NALM-1:0] alarm_set_i,
    output wire [NALM-1:0] alarm_o,
    // Interrupt pin
    input wire irq_req_i,
    output wire irq_pin_n_out_o,
    output wire irq_pin_n_oe_o,
    output wire irq_pullup_en_o
);
    reg [15:0] gp_output_values_q;
    reg [15:0] system_configuration_q;
    reg [NALM-1:0] alarm_q;
    reg [NALM-1:0] alarm_d;
    reg [7:0] sticky_q;
    reg sync_q;
    wire [NPIN-1:0] gpo_bits;
    wire mclk;
    wire strobe_rise;
    wire strobe_trig;
    wire [7:0] burst_or;
    wire [7:0] burst_or_pre;
    wire [7:0] status_src;
    wire wr_gpo;
    wire wr_cfg;
    wire rd_alm;
    wire wr_alm;

    // One-hot address decode used for both reads and writes
    function hit;
        input [6:0] a;
        input [6:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    assign wr_gpo = reg_wr_i & hit(reg_addr_i, `GPO_VALUES_ADDR);
    assign wr_cfg = reg_wr_i & hit(reg_addr_i, `SYS_CONFIG_ADDR);
    assign wr_alm = reg_wr_i & hit(reg_addr_i, `GLOBAL_ALARM_ADDR);
    assign rd_alm = reg_rd_i & hit(reg_addr_i, `GLOBAL_ALARM_ADDR);

    ////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            gp_output_values_q <= `GPO_VALUES_RST;
            system_configuration_q <= `SYS_CONFIG_RST;
        end else begin
            if (wr_gpo) begin
                gp_output_values_q <= reg_wdata_i & `GPO_RSVD_MASK;
            end
            if (wr_cfg) begin
                system_configuration_q <= reg_wdata_i;
            end
        end
    end

    // Read data is registered; unmapped addresses read zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `GPO_VALUES_ADDR: reg_rdata_o <= gp_output_values_q;
                `SYS_CONFIG_ADDR: reg_rdata_o <= system_configuration_q;
                `GLOBAL_ALARM_ADDR: reg_rdata_o <= alarm_q;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Global alarm: set wins over either clear style
    always @* begin
        alarm_d = alarm_q;
        if (rd_alm && !system_configuration_q[`CFG_ALARM_POLICY]) begin
            alarm_d = {NALM{1'b0}};
        end
        if (wr_alm && system_configuration_q[`CFG_ALARM_POLICY]) begin
            alarm_d = alarm_q & ~reg_wdata_i[NALM-1:0];
        end
        alarm_d = alarm_d | alarm_set_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            alarm_q <= {NALM{1'b0}};
        end else begin
            alarm_q <= alarm_d;
        end
    end

    assign alarm_o = alarm_q;

    ////////////////////////////////////////////////////////////////
    // General outputs; pin nine may carry the master clock instead
    assign gpo_bits = gp_output_values_q[`GPO_FIELD_HI:`GPO_FIELD_LO];

    afe_mclk_div u_mclk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(system_configuration_q[`CFG_MCLK_OUT]),
        .mclk_o(mclk)
    );

    always @* begin
        gpio_out_o = gpo_bits & gpo_enable_i;
        gpio_oe_o = gpo_enable_i;
        if (system_configuration_q[`CFG_MCLK_OUT]) begin
            gpio_out_o[NPIN-1] = mclk;
            gpio_oe_o[NPIN-1] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Data-ready strobe timing
    assign strobe_trig = conv_done_i &
        (~system_configuration_q[`CFG_READY_EDGE] | conv_last_i);

    afe_strobe_gen #(
        .CW(4)
    ) u_strobe (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .trig_i(strobe_trig),
        .width_i(system_configuration_q[`CFG_STROBE_WIDTH] ?
            `STROBE_LONG_CYC : `STROBE_SHORT_CYC),
        .strobe_o(data_ready_strobe_o),
        .rise_o(strobe_rise)
    );

    ////////////////////////////////////////////////////////////////
    // Burst status OR over the channels taking part
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_or
            wire [7:0] acc;
            wire [7:0] prev;
            if (g == 0) begin : g_first
                assign prev = 8'h00;
            end else begin : g_next
                assign prev = g_or[g-1].acc;
            end
            assign acc = prev | (ch_status_i[8*g +: 8] &
                {8{burst_mask_i[g] & channel_enable_mask_i[g]}});
        end
    endgenerate
    assign burst_or_pre = g_or[NCH-1].acc;
    assign burst_or = burst_or_pre;

    // Sticky accumulates until a live capture clears it; live samples at the strobe edge
    assign status_src = burst_first_i ? burst_or : conv_status_i;

    always @(posedge clk_i) begin
        if (rst_i) begin
            sticky_q <= 8'h00;
            status_byte_o <= 8'h00;
            result_o <= 24'h00_0000;
        end else if (strobe_rise) begin
            if (system_configuration_q[`CFG_STATUS_LIVE]) begin
                status_byte_o <= status_src;
                sticky_q <= 8'h00;
            end else begin
                status_byte_o <= sticky_q | status_src;
                sticky_q <= sticky_q | status_src;
            end
            if (system_configuration_q[`CFG_SHORT_RESULT]) begin
                result_o <= {8'h00, conv_data_i[23:8]};
            end else begin
                result_o <= conv_data_i;
            end
        end
    end

    assign status_prepend_o = system_configuration_q[`CFG_STATUS_EN];
    assign short_result_sel_o = system_configuration_q[`CFG_SHORT_RESULT];

    ////////////////////////////////////////////////////////////////
    // Sync start: rising edge of host pulse, inputs taken synchronous
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= sync_pin_i;
        end
    end

    assign conv_start_o = system_configuration_q[`CFG_SYNC_EN] &
        sync_pin_i & ~sync_q;

    ////////////////////////////////////////////////////////////////
    // Reference, clock source, CRC and drive steering
    assign bypass_external_reference_o = system_configuration_q[`CFG_REF_HI];
    assign adc_external_reference_o = system_configuration_q[`CFG_REF_LO];
    assign use_int_osc_o = ~system_configuration_q[`CFG_CLK_HI];
    assign xtal_osc_en_o =
        (system_configuration_q[`CFG_CLK_HI:`CFG_CLK_LO] == 2'b00) |
        (system_configuration_q[`CFG_CLK_HI:`CFG_CLK_LO] == 2'b11);
    assign ext_clk_sel_o =
        (system_configuration_q[`CFG_CLK_HI:`CFG_CLK_LO] == 2'b10);
    assign crc_en_o = system_configuration_q[`CFG_CRC_EN];
    assign dout_drive_hi_o = system_configuration_q[`CFG_DOUT_DRIVE];

    ////////////////////////////////////////////////////////////////
    // Interrupt pin, active low; open-drain only ever drives low
    assign irq_pin_n_out_o = ~irq_req_i;
    assign irq_pin_n_oe_o = system_configuration_q[`CFG_IRQ_DRIVER] ?
        1'b1 : irq_req_i;
    assign irq_pullup_en_o = ~system_configuration_q[`CFG_IRQ_DRIVER];
endmodule

/* shared/afe_sys_map.vh */
`ifndef AFE_SYS_MAP_VH
`define AFE_SYS_MAP_VH
// Register addresses (7-bit SPI register space)
`define GPO_VALUES_ADDR 7'h2f
`define SYS_CONFIG_ADDR 7'h30
`define GLOBAL_ALARM_ADDR 7'h33
// Reset values
`define GPO_VALUES_RST 16'h0000
`define SYS_CONFIG_RST 16'h0000
// Output data register layout
`define GPO_FIELD_HI 15
`define GPO_FIELD_LO 6
`define GPO_RSVD_MASK 16'hffc0
// System configuration field positions
`define CFG_STROBE_WIDTH 15
`define CFG_SHORT_RESULT 14
`define CFG_STATUS_LIVE 13
`define CFG_MCLK_OUT 12
`define CFG_REF_HI 11
`define CFG_REF_LO 10
`define CFG_CLK_HI 9
`define CFG_CLK_LO 8
`define CFG_CRC_EN 7
`define CFG_STATUS_EN 6
`define CFG_SYNC_EN 5
`define CFG_READY_EDGE 4
`define CFG_ALARM_POLICY 3
`define CFG_DOUT_DRIVE 2
`define CFG_IRQ_DRIVER 1
// Strobe widths in system clock cycles
`define STROBE_SHORT_CYC 4'd2
`define STROBE_LONG_CYC 4'd8
`endif

/* tb/afe_host_model.sv */
`timescale 1ns/100ps
// Host side: decoded register requests and the SYNC pin
module afe_host_model (
    // Clock
    input wire clk_i,
    // Requests and SYNC
    output logic [6:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] wdata_o,
    output logic sync_o
);
    // Idle levels from time zero
    initial begin
        addr_o = 7'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
        sync_o = 1'b0;
    end
    // Data is scrambled afterwards so a stale word can't pass
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_i) addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i) wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    // Read strobe, taken on the next edge
    task automatic rd(input logic [6:0] a);
        @(posedge clk_i) addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i) rd_o <= 1'b0;
    endtask
    // Rising SYNC edge, held two cycles
    task automatic sync_pulse();
        @(posedge clk_i) sync_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        sync_o <= 1'b0;
    endtask
endmodule

/* tb/afe_system_config_bank_asserts.sv */
`timescale 1ns/100ps
// Port checks against a shadow copy of the config word
module afe_cfg_asserts #(
    parameter NPIN = 10
) (
    input wire clk_i,
    input wire rst_i,
    input wire [6:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    input wire [NPIN-1:0] gpio_out_o,
    input wire [NPIN-1:0] gpo_enable_i,
    input wire conv_done_i,
    input wire conv_last_i,
    input wire data_ready_strobe_o,
    input wire sync_pin_i,
    input wire conv_start_o,
    input wire bypass_external_reference_o,
    input wire adc_external_reference_o,
    input wire use_int_osc_o,
    input wire xtal_osc_en_o,
    input wire ext_clk_sel_o,
    input wire crc_en_o
);
    reg [15:0] cfg_q;
    wire rdy = data_ready_strobe_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Shadow, so each check knows the selected mode
    always @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= 16'h0000;
        end else if (reg_wr_i && reg_addr_i == 7'h30) begin
            cfg_q <= reg_wdata_i;
        end
    end
    ////////////////////////////////////////
    // Config decode and strobe shape
    // Disabled pins are not driven, so only enabled bits must follow
    a_gpo_map: assert property (reg_wr_i && reg_addr_i == 7'h2f |=>
        gpio_out_o[8:0] == ($past(reg_wdata_i[14:6]) & gpo_enable_i[8:0]))
        else $error("gpo");
    a_strobe_two: assert property ($rose(rdy) && !cfg_q[15] |->
        rdy[*2] ##1 !rdy) else $error("short strobe");
    a_strobe_eight: assert property ($rose(rdy) && cfg_q[15] |->
        rdy[*8] ##1 !rdy) else $error("long strobe");
    a_strobe_cause: assert property (conv_done_i &&
        (!cfg_q[4] || conv_last_i) |=> rdy) else $error("no strobe");
    a_edge_last: assert property (conv_done_i && cfg_q[4] &&
        !conv_last_i && !rdy |=> !rdy) else $error("early strobe");
    a_sync_start: assert property (conv_start_o ==
        (cfg_q[5] && $rose(sync_pin_i))) else $error("sync start");
    a_ref_sel: assert property ({bypass_external_reference_o,
        adc_external_reference_o} == cfg_q[11:10]) else $error("ref select");
    a_clk_src: assert property ({use_int_osc_o, xtal_osc_en_o,
        ext_clk_sel_o} == {!cfg_q[9], cfg_q[9] == cfg_q[8],
        cfg_q[9:8] == 2'd2}) else $error("clock source");
    a_crc_gate: assert property (crc_en_o == cfg_q[7])
        else $error("crc enable");
    c_long: cover property (rdy && cfg_q[15]);
    c_sync: cover property (conv_start_o);
    c_last: cover property (conv_done_i && cfg_q[4] && conv_last_i);
endmodule
bind afe_system_config_bank afe_cfg_asserts #(.NPIN(NPIN)) i_chk (
    .clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .gpio_out_o,
    .conv_done_i, .conv_last_i, .data_ready_strobe_o, .sync_pin_i,
    .conv_start_o, .bypass_external_reference_o, .adc_external_reference_o, .use_int_osc_o,
    .xtal_osc_en_o, .ext_clk_sel_o, .crc_en_o, .gpo_enable_i
);

/* tb/test_afe_system_config_bank.sv */
`timescale 1ns/100ps
// Host model drives registers, the bench drives conversion events
module test_afe_system_config_bank;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic done = 1'b0, last = 1'b0, irq = 1'b0, rd_d = 1'b0;
    logic [9:0] en = 10'h000, gout, goe;
    logic [15:0] aset = 16'h0000, cfg, d, rdata, wdat;
    logic [23:0] cdata = 24'h00_0000, result;
    logic [6:0] addr;
    logic wr, rd, sync, strobe, start, srs, prep;
    logic [3:0] s;
    logic bf = 1'b0, ipo, ipe, ipu, dd;
    logic [15:0] bm = 16'h0000, cm = 16'hffff;
    logic [127:0] chs = '0;
    logic [7:0] sx, sbyte;
    logic [15:0] exp_q[$];
    int miscompares = 0, comparisons = 0, cycles = 0, starts = 0;
    // Parts under test
    afe_host_model i_host (.clk_i(clk_i), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdat), .sync_o(sync));
    afe_system_config_bank i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdat), .reg_rdata_o(rdata),
        .gpo_enable_i(en), .gpio_out_o(gout), .gpio_oe_o(goe),
        .conv_done_i(done), .conv_last_i(last), .conv_data_i(cdata),
        .conv_status_i(cdata[7:0]), .burst_first_i(bf),
        .channel_enable_mask_i(cm), .burst_mask_i(bm),
        .ch_status_i(chs), .result_o(result), .status_byte_o(sbyte),
        .status_prepend_o(prep), .short_result_sel_o(srs),
        .data_ready_strobe_o(strobe), .sync_pin_i(sync),
        .conv_start_o(start), .bypass_external_reference_o(), .adc_external_reference_o(),
        .use_int_osc_o(), .xtal_osc_en_o(), .ext_clk_sel_o(),
        .crc_en_o(), .dout_drive_hi_o(dd), .alarm_set_i(aset), .alarm_o(),
        .irq_req_i(irq), .irq_pin_n_out_o(ipo), .irq_pin_n_oe_o(ipe),
        .irq_pullup_en_o(ipu)
    );
    ////////////////////////////////////////
    task automatic complete_run();
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // Note the expected word, then ask for it
    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.rd(a);
    endtask
    // One conversion event, then count strobe cycles
    task automatic fire(input logic l, input int e);
        int n = 0;
        @(posedge clk_i) done <= 1'b1;
        last <= l;
        @(posedge clk_i) done <= 1'b0;
        repeat (12) @(posedge clk_i) n += strobe;
        chk(n == e, "strobe count");
    endtask
    // Clock, hang limit and start counting
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        starts += start;
        if (cycles == 2000) begin
            miscompares++;
            complete_run();
        end
    end
    // Read data lands a cycle after the request, oldest note first
    always @(posedge clk_i) begin
        rd_d <= rd;
        if (rd_d) begin
            chk(rdata === exp_q.pop_front(), "read data");
        end
    end
    initial begin
        d = 16'($urandom(32'h9905));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, unmapped place, reserved bits
        rdc(7'h2f, 16'h0000);
        rdc(7'h30, 16'h0000);
        rdc(7'h7f, 16'h0000);
        d = 16'($urandom);
        en <= 10'($urandom);
        i_host.wr(7'h2f, d);
        rdc(7'h2f, d & 16'hffc0);
        #1 chk(((gout ^ d[15:6]) & en) === 10'h000 && goe === en,
            "gpo pins");
        // Every reference and clock code, random levels beside
        for (int i = 0; i < 4; i++) begin
            cfg = 16'($urandom) & 16'h60ce;
            cfg[11:10] = i[1:0];
            cfg[9:8] = ~i[1:0];
            irq <= 1'($urandom);
            i_host.wr(7'h30, cfg);
            rdc(7'h30, cfg);
            #1 chk(srs === cfg[14] && prep === cfg[6], "levels");
            chk(dd === cfg[2] && ipu === !cfg[1], "drive levels");
            chk(ipe === (cfg[1] | irq) && ipo === !irq, "irq pin");
        end
        // Strobe widths, word widths, last-channel policy
        cdata <= 24'($urandom);
        i_host.wr(7'h30, 16'h4000);
        fire(1'b0, 2);
        chk(result === {8'h00, cdata[23:8]}, "short word");
        i_host.wr(7'h30, 16'h8000);
        fire(1'b0, 8);
        chk(result === cdata, "full word");
        i_host.wr(7'h30, 16'h0010);
        fire(1'b0, 0);
        fire(1'b1, 2);
        // SYNC starts conversion only in sync mode
        for (int e = 0; e < 2; e++) begin
            i_host.wr(7'h30, {10'h000, e[0], 5'h00});
            i_host.sync_pulse();
            chk(starts == e, "sync start");
        end
        // Alarm clear on read, then write-one-to-clear
        for (int p = 0; p < 2; p++) begin
            i_host.wr(7'h30, {12'h000, p[0], 3'h0});
            d = 16'($urandom) | 16'h0001;
            aset <= d;
            @(posedge clk_i) aset <= 16'h0000;
            rdc(7'h33, d);
            rdc(7'h33, p ? d : 16'h0000);
            i_host.wr(7'h33, d);
            rdc(7'h33, 16'h0000);
        end
        // Burst status OR in live mode, then sticky accumulation
        bf <= 1'b1;
        bm <= 16'($urandom);
        cm <= 16'($urandom);
        for (int i = 0; i < 4; i++) begin
            chs[32*i +: 32] <= $urandom;
        end
        i_host.wr(7'h30, 16'h2040);
        sx = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (bm[i] && cm[i]) begin
                sx = sx | chs[8*i +: 8];
            end
        end
        fire(1'b0, 2);
        chk(sbyte === sx, "burst status");
        bf <= 1'b0;
        i_host.wr(7'h30, 16'h0040);
        // Live mode emptied the sticky bits, so they build up from zero
        for (int k = 0; k < 2; k++) begin
            sx = (k == 0) ? 8'h00 : cdata[7:0];
            cdata <= 24'($urandom);
            fire(1'b0, 2);
            chk(sbyte === (sx | cdata[7:0]), "sticky status");
        end
        // Master clock overrides pin nine
        i_host.wr(7'h30, 16'h1000);
        #2;
        repeat (4) begin
            s = {s[2:0], gout[9]};
            #5;
        end
        chk(goe[9] === 1'b1 && $countones(s) == 2, "mclk");
        repeat (3) @(posedge clk_i);
        complete_run();
    end
endmodule
